// ===== hdl/alarm_time_regs.sv
// Alarm weekday/hours and minutes/seconds registers behind an APB slave
// Assumes an APB master on pclk; alarm fields have no reset value
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "alarm_regs_defs.svh"

module alarm_time_regs
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output alarm_regs_pkg::alarm_time_t    alarm_time,
    output logic                           clock_write_unlock
);

    alarm_regs_pkg::state_t state_reg;
    alarm_regs_pkg::state_t state_next;

    // ======================================================================
    // Register images
    function automatic logic [15:0] wdhr_image(input alarm_regs_pkg::alarm_time_t a);
        wdhr_image = {5'h00, a.alarm_weekday_digit, 2'h0, a.alarm_hour_tens, a.alarm_hour_ones};
    endfunction

    function automatic logic [15:0] minsec_image(input alarm_regs_pkg::alarm_time_t a);
        minsec_image = {1'h0, a.alarm_minute_tens, a.alarm_minute_ones,
                        1'h0, a.alarm_second_tens, a.alarm_second_ones};
    endfunction

    // ======================================================================
    // Bus decode and next state
    logic        setup;
    logic        wr;
    logic [15:0] wlo;

    always_comb
    begin
        state_next         = state_reg;
        setup              = psel && !penable;
        wr                 = setup && pwrite;
        wlo                = pwdata[15:0];
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        if (setup)
        begin
            state_next.pready = 1'b1;
            state_next.prdata = 32'h0000_0000;
            unique case (paddr)
                `OFS_ALARM_WEEKDAY_HOURS:
                begin
                    state_next.prdata[15:0] = wdhr_image(state_reg.alarm);
                    if (wr && state_reg.clock_write_unlock)
                    begin
                        if (pstrb[1])
                            state_next.alarm.alarm_weekday_digit = wlo[`ALARM_WEEKDAY_DIGIT_MSB:`ALARM_WEEKDAY_DIGIT_LSB];
                        if (pstrb[0])
                        begin
                            state_next.alarm.alarm_hour_tens = wlo[`ALARM_HOUR_TENS_MSB:`ALARM_HOUR_TENS_LSB];
                            state_next.alarm.alarm_hour_ones = wlo[`ALARM_HOUR_ONES_MSB:`ALARM_HOUR_ONES_LSB];
                        end
                    end
                end
                `OFS_ALARM_MINUTES_SECONDS:
                begin
                    state_next.prdata[15:0] = minsec_image(state_reg.alarm);
                    if (wr && state_reg.clock_write_unlock)
                    begin
                        if (pstrb[1])
                        begin
                            state_next.alarm.alarm_minute_tens = wlo[`ALARM_MINUTE_TENS_MSB:`ALARM_MINUTE_TENS_LSB];
                            state_next.alarm.alarm_minute_ones = wlo[`ALARM_MINUTE_ONES_MSB:`ALARM_MINUTE_ONES_LSB];
                        end
                        if (pstrb[0])
                        begin
                            state_next.alarm.alarm_second_tens = wlo[`ALARM_SECOND_TENS_MSB:`ALARM_SECOND_TENS_LSB];
                            state_next.alarm.alarm_second_ones = wlo[`ALARM_SECOND_ONES_MSB:`ALARM_SECOND_ONES_LSB];
                        end
                    end
                end
                `OFS_CLOCK_CONTROL:
                begin
                    state_next.prdata[`UNLOCK_BIT] = state_reg.clock_write_unlock;
                    if (wr && pstrb[0])
                        state_next.clock_write_unlock = pwdata[`UNLOCK_BIT];
                end
                default:
                    state_next.pslverr = 1'b1;
            endcase
        end
    end

    // ======================================================================
    // State register; alarm fields keep no reset value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg.clock_write_unlock <= `RST_UNLOCK;
            state_reg.prdata             <= 32'h0000_0000;
            state_reg.pready             <= 1'b0;
            state_reg.pslverr            <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata             = state_reg.prdata;
    assign pready             = state_reg.pready;
    assign pslverr            = state_reg.pslverr;
    assign alarm_time         = state_reg.alarm;
    assign clock_write_unlock = state_reg.clock_write_unlock;

    // ======================================================================
    // Assertions
    sequence locked_write_wdhr;
        psel && !penable && pwrite && paddr == `OFS_ALARM_WEEKDAY_HOURS && !clock_write_unlock;
    endsequence

    sequence locked_write_minsec;
        psel && !penable && pwrite && paddr == `OFS_ALARM_MINUTES_SECONDS && !clock_write_unlock;
    endsequence

    a_locked_wdhr_hold: assert property (@(posedge pclk) disable iff (!presetn)
        locked_write_wdhr |=> $stable(wdhr_image(alarm_time)))
        else $error("weekday/hours changed while locked");

    a_locked_minsec_hold: assert property (@(posedge pclk) disable iff (!presetn)
        locked_write_minsec |=> $stable(minsec_image(alarm_time)))
        else $error("minutes/seconds changed while locked");

    a_alarm_weekday_digit_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && pstrb[1] && paddr == `OFS_ALARM_WEEKDAY_HOURS && clock_write_unlock)
        |=> alarm_time.alarm_weekday_digit == $past(pwdata[10:8]))
        else $error("weekday field not taken from bits 10:8");

    a_hour_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && pstrb[0] && paddr == `OFS_ALARM_WEEKDAY_HOURS && clock_write_unlock)
        |=> alarm_time.alarm_hour_tens == $past(pwdata[5:4]) && alarm_time.alarm_hour_ones == $past(pwdata[3:0]))
        else $error("hour fields not taken from bits 5:0");

    a_min_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && pstrb[1] && paddr == `OFS_ALARM_MINUTES_SECONDS && clock_write_unlock)
        |=> {alarm_time.alarm_minute_tens, alarm_time.alarm_minute_ones} == $past(pwdata[14:8]))
        else $error("minute fields not taken from bits 14:8");

    a_sec_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && pstrb[0] && paddr == `OFS_ALARM_MINUTES_SECONDS && clock_write_unlock)
        |=> {alarm_time.alarm_second_tens, alarm_time.alarm_second_ones} == $past(pwdata[6:0]))
        else $error("second fields not taken from bits 6:0");

    a_wdhr_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == `OFS_ALARM_WEEKDAY_HOURS)
        |=> pready && (prdata & ~{16'h0000, `MASK_WDHR}) == 32'h0000_0000)
        else $error("unimplemented weekday/hours bits read nonzero");

    a_minsec_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == `OFS_ALARM_MINUTES_SECONDS)
        |=> pready && (prdata & ~{16'h0000, `MASK_MINSEC}) == 32'h0000_0000)
        else $error("unimplemented minutes/seconds bits read nonzero");

endmodule

// ===== hdl/alarm_regs_defs.svh
// Offsets, field positions and reset values for the alarm time registers
// Assumes inclusion by bare name from the design module and the bench
`ifndef ALARM_REGS_DEFS_SVH
`define ALARM_REGS_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses on APB)
`define OFS_ALARM_WEEKDAY_HOURS    12'h000
`define OFS_ALARM_MINUTES_SECONDS  12'h004
`define OFS_CLOCK_CONTROL          12'h008

// ==========================================================================
// Field positions
`define ALARM_WEEKDAY_DIGIT_LSB    8
`define ALARM_WEEKDAY_DIGIT_MSB    10
`define ALARM_HOUR_TENS_LSB   4
`define ALARM_HOUR_TENS_MSB   5
`define ALARM_HOUR_ONES_LSB   0
`define ALARM_HOUR_ONES_MSB   3
`define ALARM_MINUTE_TENS_LSB  12
`define ALARM_MINUTE_TENS_MSB  14
`define ALARM_MINUTE_ONES_LSB  8
`define ALARM_MINUTE_ONES_MSB  11
`define ALARM_SECOND_TENS_LSB  4
`define ALARM_SECOND_TENS_MSB  6
`define ALARM_SECOND_ONES_LSB  0
`define ALARM_SECOND_ONES_MSB  3
`define UNLOCK_BIT  0

// ==========================================================================
// Implemented bit masks and reset values
`define MASK_WDHR    16'h073F
`define MASK_MINSEC  16'h7F7F
`define RST_UNLOCK   1'h0

`endif

// ===== hdl/alarm_regs_pkg.sv
// Types shared by the alarm time register block
// Assumes nothing beyond a SystemVerilog compiler
package alarm_regs_pkg;

    typedef struct packed
    {
        logic [2:0] alarm_weekday_digit;
        logic [1:0] alarm_hour_tens;
        logic [3:0] alarm_hour_ones;
        logic [2:0] alarm_minute_tens;
        logic [3:0] alarm_minute_ones;
        logic [2:0] alarm_second_tens;
        logic [3:0] alarm_second_ones;
    } alarm_time_t;

    typedef struct packed
    {
        alarm_time_t  alarm;
        logic         clock_write_unlock;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
    } state_t;

endpackage

// ===== tb/alarm_time_regs_tb.sv
// Self-checking bench for the alarm weekday/hours and minutes/seconds registers
// Assumes the design files under hdl/ are compiled first
`timescale 1ns/1ns
`include "alarm_regs_defs.svh"

module alarm_time_regs_tb;

    // ==========================================================================
    // Stimulus and observed signals
    logic                          pclk;
    logic                          presetn;
    logic                          psel;
    logic                          penable;
    logic                          pwrite;
    logic [11:0]                   paddr;
    logic [31:0]                   pwdata;
    logic [3:0]                    pstrb;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    alarm_regs_pkg::alarm_time_t   alarm_time;
    logic                          clock_write_unlock;
    logic [31:0]                   rd_v;
    logic                          err_v;
    int                            num_errors = 0;
    int                            tests_run = 0;

    alarm_time_regs DUT
    (
        .pclk               (pclk),
        .presetn            (presetn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pstrb              (pstrb),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .alarm_time         (alarm_time),
        .clock_write_unlock (clock_write_unlock)
    );

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // ==========================================================================
    // Checking and bus tasks
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Setup cycle, then access phase held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000, 4'h0);
    endtask

    // ==========================================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check("unlock_rst", {31'h00000000, clock_write_unlock}, 32'h00000000);
        check("pready_rst", {31'h00000000, pready}, 32'h00000000);
        apb(1'b1, `OFS_CLOCK_CONTROL, 32'h00000001, 4'hF);
        check("unlock_set", {31'h00000000, clock_write_unlock}, 32'h00000001);
        rd(`OFS_CLOCK_CONTROL);
        check("unlock_rd", rd_v, 32'h00000001);
        check("mapped_err", {31'h00000000, err_v}, 32'h00000000);
        apb(1'b1, `OFS_ALARM_WEEKDAY_HOURS, 32'h00000623, 4'hF);
        apb(1'b1, `OFS_ALARM_MINUTES_SECONDS, 32'h00005959, 4'hF);
        rd(`OFS_ALARM_WEEKDAY_HOURS);
        check("wdhr", rd_v, 32'h00000623);
        check("fields", {9'h000, alarm_time}, {9'h000, 3'h6, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h9});
        rd(`OFS_ALARM_MINUTES_SECONDS);
        check("minsec", rd_v, 32'h00005959);
        // Lane 0 only: minute digits stay, second digits cleared
        apb(1'b1, `OFS_ALARM_MINUTES_SECONDS, 32'h00000000, 4'h1);
        rd(`OFS_ALARM_MINUTES_SECONDS);
        check("minsec_lane", rd_v, 32'h00005900);
        apb(1'b1, `OFS_ALARM_WEEKDAY_HOURS, 32'hFFFFFFFF, 4'hF);
        rd(`OFS_ALARM_WEEKDAY_HOURS);
        check("wdhr_ones", rd_v, 32'h0000073F);
        check("hour_ones", {28'h0000000, alarm_time.alarm_hour_ones}, 32'h0000000F);
        check("hour_tens", {30'h00000000, alarm_time.alarm_hour_tens}, 32'h00000003);
        // Lane 1 only: weekday cleared, hour digits stay
        apb(1'b1, `OFS_ALARM_WEEKDAY_HOURS, 32'h00000000, 4'h2);
        rd(`OFS_ALARM_WEEKDAY_HOURS);
        check("wdhr_lane", rd_v, 32'h0000003F);
        apb(1'b1, `OFS_ALARM_MINUTES_SECONDS, 32'hFFFFFFFF, 4'hF);
        rd(`OFS_ALARM_MINUTES_SECONDS);
        check("minsec_ones", rd_v, 32'h00007F7F);
        apb(1'b1, `OFS_ALARM_WEEKDAY_HOURS, 32'h00000412, 4'hF);
        // Lock, then try to overwrite both registers
        apb(1'b1, `OFS_CLOCK_CONTROL, 32'h00000000, 4'hF);
        check("unlock_clr", {31'h00000000, clock_write_unlock}, 32'h00000000);
        rd(`OFS_CLOCK_CONTROL);
        check("unlock_rd_clr", rd_v, 32'h00000000);
        apb(1'b1, `OFS_ALARM_WEEKDAY_HOURS, 32'h00000109, 4'hF);
        check("locked_err", {31'h00000000, err_v}, 32'h00000000);
        apb(1'b1, `OFS_ALARM_MINUTES_SECONDS, 32'h00001234, 4'hF);
        rd(`OFS_ALARM_WEEKDAY_HOURS);
        check("wdhr_locked", rd_v, 32'h00000412);
        rd(`OFS_ALARM_MINUTES_SECONDS);
        check("minsec_locked", rd_v, 32'h00007F7F);
        rd(12'h00C);
        check("unmapped_err", {31'h00000000, err_v}, 32'h00000001);
        check("unmapped_data", rd_v, 32'h00000000);
        wrap_up();
    end

    // ==========================================================================
    // Watchdog
    initial
    begin
        #100000;
        num_errors++;
        wrap_up();
    end

endmodule
